/* File: design/pfpp_pkg.sv */
// Purpose: Shared constants and types of the parallel flash programming port.
// Assumes: One clock domain; the flash controller sits behind a request/ack port.
// Notes: Command codes and mode codes are fixed by the programming protocol.
package pfpp_pkg;

  // ==========================================================================
  // Mode bus codes
  localparam logic [3:0] MODE_CMD = 4'h0;
  localparam logic [3:0] MODE_ADDR_A = 4'h1;
  localparam logic [3:0] MODE_ADDR_D = 4'h4;
  localparam logic [3:0] MODE_DATA = 4'h5;

  // ==========================================================================
  // Command codes
  localparam logic [15:0] CMD_READ = 16'h0011;
  localparam logic [15:0] CMD_WRITE_PAGE = 16'h0012;
  localparam logic [15:0] CMD_WRITE_PAGE_LOCK = 16'h0022;
  localparam logic [15:0] CMD_ERASE_WRITE_PAGE = 16'h0032;
  localparam logic [15:0] CMD_ERASE_WRITE_PAGE_LOCK = 16'h0042;
  localparam logic [15:0] CMD_ERASE_ALL = 16'h0013;
  localparam logic [15:0] CMD_SET_LOCK = 16'h0014;
  localparam logic [15:0] CMD_CLEAR_LOCK = 16'h0024;
  localparam logic [15:0] CMD_GET_LOCK = 16'h0015;
  localparam logic [15:0] CMD_SET_GPNVM = 16'h0034;
  localparam logic [15:0] CMD_CLEAR_GPNVM = 16'h0044;
  localparam logic [15:0] CMD_GET_GPNVM = 16'h0025;
  localparam logic [15:0] CMD_SET_SECURITY = 16'h0054;
  localparam logic [15:0] CMD_GET_SECURITY = 16'h0035;
  localparam logic [15:0] CMD_WRITE_MEMORY = 16'h001F;
  localparam logic [15:0] CMD_GET_VERSION = 16'h001E;

  // ==========================================================================
  // Register map, byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_COMMAND = 8'h08;
  localparam logic [7:0] REG_ADDRESS = 8'h0C;
  localparam logic [7:0] REG_VERSION = 8'h10;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam logic CTRL_ENABLE_RESET = 1'b1;
  localparam int STAT_READY_BIT = 0;
  localparam int STAT_PROG_MODE_BIT = 1;
  localparam int STAT_DIRTY_BIT = 2;
  localparam int STAT_STATE_LSB = 8;

  // ==========================================================================
  // Default sizes and reset values
  localparam int DATA_WIDTH_DEFAULT = 16;
  localparam int PAGE_WORDS_LOG2_DEFAULT = 7;
  localparam logic [15:0] CMD_RESET = 16'h0000;
  localparam logic [31:0] ADDR_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    FOP_READ = 2'h0,
    FOP_LOAD = 2'h1,
    FOP_COMMIT = 2'h2,
    FOP_EXEC = 2'h3
  } pfpp_fop_e;

  typedef struct packed {
    pfpp_fop_e op;
    logic [15:0] cmd;
    logic [31:0] addr;
    logic [15:0] wdata;
  } pfpp_flash_req_s;

  typedef enum logic [6:0] {
    ST_IDLE = 7'b000_0001,
    ST_FLUSH = 7'b000_0010,
    ST_ACT = 7'b000_0100,
    ST_WAIT_ACK = 7'b000_1000,
    ST_WAIT_OE_LO = 7'b001_0000,
    ST_WAIT_OE_HI = 7'b010_0000,
    ST_WAIT_STB_HI = 7'b100_0000
  } pfpp_state_e;

endpackage

/* File: design/pfpp_sync2.sv */
// Purpose: Two-flop level synchroniser for the handshake strobes.
// Assumes: Inputs may change at any time relative to CLK.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
module pfpp_sync2 #(
  parameter int WIDTH = 2,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_q <= INIT;
      dout <= INIT;
    end
    else
    begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule

/* File: design/pfpp_port.sv */
// Purpose: Parallel flash programming port: handshake engine, command and
//   address registers, page flush control and a Wishbone register slave.
// Assumes: Flash controller answers each FLASH_REQ with one FLASH_ACK pulse.
// Notes: Pins are split into input, output and output enable.
// Contract
// - Mode code selects target register
// - Command mode stores data as command
// - Read, write page, write-lock codes
// - Erase-write and erase-write-lock codes
// - Erase all, lock bits, memory write
// - GPNVM set/clear and security set codes
// - Query codes for bits and version
// - Ready low while busy, high idle
// - Handshake ends: strobe high, ready high
// - Strobe low means valid mode/data
// - Port pins reset as pulled-up inputs
// - Other pins pulled-up inputs in mode
// - Oscillator bypassed in programming mode
// - Data bus 16 or 8 bits
// - Write: latch, drop ready, execute, raise
// - Read: drive data, valid low, release
// - Data handshakes auto-increment address (code: only for read, page write and memory write)
// - Flush page buffer on page change/command
`timescale 1ns/1ps
module pfpp_port
  import pfpp_pkg::*;
#(
  parameter int DW = DATA_WIDTH_DEFAULT,
  parameter int PAGE_WORDS_LOG2 = PAGE_WORDS_LOG2_DEFAULT,
  // Arbitrary neutral value.
  parameter logic [31:0] VERSION_ID = 32'h0000_0001
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic TEST_MODE_SELECT,
  input wire logic PROG_ENABLE_SEL_A,
  input wire logic PROG_ENABLE_SEL_B,
  input wire logic PROG_ENABLE_SEL_C,
  input wire logic COMMAND_STROBE_N,
  input wire logic OUTPUT_ENABLE_PIN_N,
  input wire logic [3:0] MODE_SELECT_BUS,
  input wire logic [DW-1:0] PARALLEL_DATA_BUS_I,
  output logic [DW-1:0] PARALLEL_DATA_BUS_O,
  output logic PARALLEL_DATA_BUS_OE,
  output logic READY_O,
  output logic READY_OE,
  output logic DATA_VALID_N_O,
  output logic DATA_VALID_N_OE,
  output logic PORT_PULLUP_EN,
  output logic GPIO_PULLUP_ALL,
  output logic CLOCK_BYPASS,
  output logic FLASH_REQ,
  output pfpp_flash_req_s FLASH_REQ_DATA,
  input wire logic FLASH_ACK,
  input wire logic [15:0] FLASH_RDATA
);

  // ==========================================================================
  // Elaboration checks
  // bus width
  if (DW != 8 && DW != 16)
  begin : g_bad_dw
    $error("pfpp_port: DW must be 8 or 16");
  end
  if (PAGE_WORDS_LOG2 < 1 || PAGE_WORDS_LOG2 > 16)
  begin : g_bad_page
    $error("pfpp_port: PAGE_WORDS_LOG2 out of range");
  end

  // ==========================================================================
  // Helpers
  function automatic logic is_query(input logic [15:0] c);
    return (c == CMD_GET_LOCK) || (c == CMD_GET_GPNVM) || (c == CMD_GET_SECURITY) ||
      (c == CMD_GET_VERSION);
  endfunction

  function automatic logic is_page_write(input logic [15:0] c);
    return (c == CMD_WRITE_PAGE) || (c == CMD_WRITE_PAGE_LOCK) ||
      (c == CMD_ERASE_WRITE_PAGE) || (c == CMD_ERASE_WRITE_PAGE_LOCK);
  endfunction

  function automatic logic [31:0] page_of(input logic [31:0] a);
    return a >> PAGE_WORDS_LOG2;
  endfunction

  logic [15:0] data_in;
  assign data_in = 16'(PARALLEL_DATA_BUS_I);

  // ==========================================================================
  // Synchronisers and mode detect
  logic [1:0] pins_sync;
  logic stb_n;
  logic oe_n;
  logic prog_mode_q;
  logic enable_q;

  pfpp_sync2 #(.WIDTH(2), .INIT(2'b11)) u_sync (
    .clk(CLK),
    .reset_n(RESET_N),
    .din({COMMAND_STROBE_N, OUTPUT_ENABLE_PIN_N}),
    .dout(pins_sync)
  );
  assign stb_n = pins_sync[1];
  assign oe_n = pins_sync[0];

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      prog_mode_q <= 1'b0;
      GPIO_PULLUP_ALL <= 1'b0;
      CLOCK_BYPASS <= 1'b0;
      PORT_PULLUP_EN <= 1'b1;
    end
    else
    begin
      prog_mode_q <= TEST_MODE_SELECT & PROG_ENABLE_SEL_A & PROG_ENABLE_SEL_B &
        ~PROG_ENABLE_SEL_C;
      GPIO_PULLUP_ALL <= prog_mode_q;
      CLOCK_BYPASS <= prog_mode_q;
      PORT_PULLUP_EN <= 1'b1;
    end
  end

  // ==========================================================================
  // Handshake engine
  pfpp_state_e state_q;
  logic [3:0] mode_q;
  logic [15:0] latch_q;
  logic [15:0] cmd_q;
  logic [31:0] addr_q;
  logic [31:0] page_q;
  logic dirty_q;
  logic [15:0] rdata_q;
  logic read_pend_q;
  logic need_flush;
  logic [31:0] addr_set;

  assign need_flush = dirty_q && ((MODE_SELECT_BUS == MODE_CMD) ||
    (MODE_SELECT_BUS == MODE_DATA && is_page_write(cmd_q) &&
     page_of(addr_q) != page_q));

  always_comb
  begin
    addr_set = addr_q;
    for (int i = 0; i < 32; i++)
    begin
      if (i / DW == int'(mode_q) - 1)
      begin
        addr_set[i] = latch_q[i % DW];
      end
    end
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      state_q <= ST_IDLE;
      mode_q <= MODE_CMD;
      latch_q <= 16'h0000;
      cmd_q <= CMD_RESET;
      addr_q <= ADDR_RESET;
      page_q <= ADDR_RESET;
      dirty_q <= 1'b0;
      rdata_q <= 16'h0000;
      read_pend_q <= 1'b0;
      READY_O <= 1'b1;
      READY_OE <= 1'b0;
      DATA_VALID_N_O <= 1'b1;
      DATA_VALID_N_OE <= 1'b0;
      PARALLEL_DATA_BUS_O <= '0;
      PARALLEL_DATA_BUS_OE <= 1'b0;
      FLASH_REQ <= 1'b0;
      FLASH_REQ_DATA <= '0;
    end
    else
    begin
      FLASH_REQ <= 1'b0;
      READY_OE <= prog_mode_q;
      DATA_VALID_N_OE <= prog_mode_q;
      unique case (state_q)
        ST_IDLE:
        begin
          if (prog_mode_q && enable_q && !stb_n)
          begin
            mode_q <= MODE_SELECT_BUS;
            latch_q <= data_in;
            READY_O <= 1'b0;
            if (need_flush)
            begin
              FLASH_REQ <= 1'b1;
              FLASH_REQ_DATA <= '{op: FOP_COMMIT, cmd: cmd_q, addr: page_q, wdata: 16'h0000};
              state_q <= ST_FLUSH;
            end
            else
            begin
              state_q <= ST_ACT;
            end
          end
        end
        ST_FLUSH:
        begin
          if (FLASH_ACK)
          begin
            dirty_q <= 1'b0;
            state_q <= ST_ACT;
          end
        end
        ST_ACT:
        begin
          state_q <= ST_WAIT_STB_HI;
          if (mode_q == MODE_CMD)
          begin
            cmd_q <= latch_q;
          end
          else if (mode_q >= MODE_ADDR_A && mode_q <= MODE_ADDR_D)
          begin
            addr_q <= addr_set;
          end
          else if (mode_q == MODE_DATA)
          begin
            state_q <= ST_WAIT_ACK;
            FLASH_REQ <= 1'b1;
            read_pend_q <= (cmd_q == CMD_READ) || is_query(cmd_q);
            if (cmd_q == CMD_READ)
            begin
              FLASH_REQ_DATA <= '{op: FOP_READ, cmd: cmd_q, addr: addr_q, wdata: 16'h0000};
            end
            else if (is_page_write(cmd_q) || cmd_q == CMD_WRITE_MEMORY)
            begin
              FLASH_REQ_DATA <= '{op: FOP_LOAD, cmd: cmd_q, addr: addr_q, wdata: latch_q};
              dirty_q <= is_page_write(cmd_q);
              page_q <= page_of(addr_q);
            end
            else
            begin
              FLASH_REQ_DATA <= '{op: FOP_EXEC, cmd: cmd_q, addr: addr_q, wdata: latch_q};
            end
            if (cmd_q == CMD_READ || is_page_write(cmd_q) || cmd_q == CMD_WRITE_MEMORY)
            begin
              addr_q <= addr_q + 32'h0000_0001;
            end
          end
        end
        ST_WAIT_ACK:
        begin
          if (FLASH_ACK)
          begin
            rdata_q <= FLASH_RDATA;
            state_q <= read_pend_q ? ST_WAIT_OE_LO : ST_WAIT_STB_HI;
          end
        end
        ST_WAIT_OE_LO:
        begin
          if (!oe_n)
          begin
            PARALLEL_DATA_BUS_O <= rdata_q[DW-1:0];
            PARALLEL_DATA_BUS_OE <= 1'b1;
            DATA_VALID_N_O <= 1'b0;
            state_q <= ST_WAIT_OE_HI;
          end
        end
        ST_WAIT_OE_HI:
        begin
          if (oe_n)
          begin
            PARALLEL_DATA_BUS_OE <= 1'b0;
            DATA_VALID_N_O <= 1'b1;
            state_q <= ST_WAIT_STB_HI;
          end
        end
        ST_WAIT_STB_HI:
        begin
          if (stb_n)
          begin
            READY_O <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Wishbone register slave
  logic wb_hit;
  assign wb_hit = WB_CYC_I && WB_STB_I && !WB_ACK_O;

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
      enable_q <= CTRL_ENABLE_RESET;
    end
    else
    begin
      WB_ACK_O <= wb_hit;
      WB_DAT_O <= 32'h0000_0000;
      if (wb_hit && WB_WE_I && WB_ADR_I == REG_CTRL && WB_SEL_I[0])
      begin
        enable_q <= WB_DAT_I[CTRL_ENABLE_BIT];
      end
      if (wb_hit && !WB_WE_I)
      begin
        unique case (WB_ADR_I)
          REG_CTRL: WB_DAT_O[CTRL_ENABLE_BIT] <= enable_q;
          REG_STATUS:
          begin
            WB_DAT_O[STAT_READY_BIT] <= READY_O;
            WB_DAT_O[STAT_PROG_MODE_BIT] <= prog_mode_q;
            WB_DAT_O[STAT_DIRTY_BIT] <= dirty_q;
            WB_DAT_O[STAT_STATE_LSB +: 7] <= state_q;
          end
          REG_COMMAND: WB_DAT_O[15:0] <= cmd_q;
          REG_ADDRESS: WB_DAT_O <= addr_q;
          REG_VERSION: WB_DAT_O <= VERSION_ID;
          default: WB_DAT_O <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

/* File: tb/pfpp_checker.sv */
// Purpose: Concurrent checks on the programming port pins.
// Assumes: One clock domain with an asynchronous active-low reset.
// Notes: Bound to pfpp_port after the module.
`timescale 1ns/1ps
module pfpp_checker (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O,
  input wire logic COMMAND_STROBE_N,
  input wire logic OUTPUT_ENABLE_PIN_N,
  input wire logic PARALLEL_DATA_BUS_OE,
  input wire logic READY_O,
  input wire logic DATA_VALID_N_O,
  input wire logic FLASH_REQ
);
  // ==========================================================================
  // Handshake and bus checks
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);
  sequence oe_released;
    $rose(OUTPUT_ENABLE_PIN_N) && PARALLEL_DATA_BUS_OE;
  endsequence
  sequence wb_taken;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  rdy_fall_a:
    assert property ($fell(READY_O) |-> !$past(COMMAND_STROBE_N, 2)) else $error("ready fell");
  rdy_rise_a:
    assert property ($rose(READY_O) |-> $past(COMMAND_STROBE_N, 2)) else $error("ready rose");
  rdy_hold_a:
    assert property (!READY_O && !COMMAND_STROBE_N |=> !READY_O) else $error("ready early");
  bus_release_a:
    assert property (oe_released |-> ##[1:5] !PARALLEL_DATA_BUS_OE) else $error("bus held");
  valid_bus_a:
    assert property (!DATA_VALID_N_O |-> PARALLEL_DATA_BUS_OE && !READY_O) else $error("valid");
  req_busy_a:
    assert property (FLASH_REQ |-> !READY_O) else $error("request while ready");
  req_pulse_a:
    assert property (FLASH_REQ |=> !FLASH_REQ) else $error("request not a pulse");
  wb_answer_a:
    assert property (wb_taken |=> WB_ACK_O) else $error("no ack");
  ack_pulse_a:
    assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack held");
endmodule

bind pfpp_port pfpp_checker pfpp_checker_i (.*);

/* File: tb/pfpp_flash_model.sv */
// Purpose: Behavioural flash controller that answers the port's requests.
// Assumes: One request outstanding at a time.
// Notes: Read data is the low address half XOR A5A5, so the bench can predict it.
`timescale 1ns/1ps
module pfpp_flash_model
  import pfpp_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [3:0] lat,
  input wire logic req,
  input wire pfpp_flash_req_s req_data,
  output logic ack,
  output logic [15:0] rdata
);
  // ==========================================================================
  // Request timing
  logic [4:0] cnt_q;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_q <= 5'h00;
      ack <= 1'b0;
      rdata <= 16'h0000;
    end
    else
    begin
      ack <= (cnt_q == 5'h01);
      rdata <= (cnt_q == 5'h01) ? (req_data.addr[15:0] ^ 16'hA5A5) : ~rdata;
      if (req)
        cnt_q <= {1'b0, lat} + 5'h01;
      else if (cnt_q != 5'h00)
        cnt_q <= cnt_q - 5'h01;
    end
  end
endmodule

/* File: tb/pfpp_port_tb_top.sv */
// Purpose: Self-checking bench for the parallel flash programming port.
// Assumes: Sixteen-bit data bus and default page size.
// Notes: Released port lines read high through their pull-ups.
`timescale 1ns/1ps
module pfpp_port_tb_top
  import pfpp_pkg::*;
;
  logic CLK, RESET_N, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O, FLASH_REQ, FLASH_ACK, drv;
  logic TEST_MODE_SELECT, PROG_ENABLE_SEL_A, PROG_ENABLE_SEL_B, PROG_ENABLE_SEL_C;
  logic COMMAND_STROBE_N, OUTPUT_ENABLE_PIN_N, PARALLEL_DATA_BUS_OE, READY_O, READY_OE;
  logic DATA_VALID_N_O, DATA_VALID_N_OE, PORT_PULLUP_EN, GPIO_PULLUP_ALL, CLOCK_BYPASS;
  logic [7:0] WB_ADR_I;
  logic [3:0] WB_SEL_I, MODE_SELECT_BUS, lat;
  logic [31:0] WB_DAT_I, WB_DAT_O, rd;
  logic [15:0] PARALLEL_DATA_BUS_I, PARALLEL_DATA_BUS_O, FLASH_RDATA, tb_d;
  pfpp_flash_req_s FLASH_REQ_DATA;
  pfpp_flash_req_s rq[$];
  int num_errors, num_checks;
  localparam logic [15:0] CODES [16] = '{CMD_READ, CMD_WRITE_PAGE, CMD_WRITE_PAGE_LOCK,
    CMD_ERASE_WRITE_PAGE, CMD_ERASE_WRITE_PAGE_LOCK, CMD_ERASE_ALL, CMD_SET_LOCK,
    CMD_CLEAR_LOCK, CMD_GET_LOCK, CMD_SET_GPNVM, CMD_CLEAR_GPNVM, CMD_GET_GPNVM,
    CMD_SET_SECURITY, CMD_GET_SECURITY, CMD_WRITE_MEMORY, CMD_GET_VERSION};

  assign PARALLEL_DATA_BUS_I = PARALLEL_DATA_BUS_OE ? PARALLEL_DATA_BUS_O :
    (drv ? tb_d : 16'hFFFF);

  pfpp_port pfpp_port_i (.*);
  pfpp_flash_model pfpp_flash_model_i (.clk(CLK), .reset_n(RESET_N), .lat(lat),
    .req(FLASH_REQ), .req_data(FLASH_REQ_DATA), .ack(FLASH_ACK), .rdata(FLASH_RDATA));

  always @(posedge CLK)
    if (FLASH_REQ === 1'b1)
      rq.push_back(FLASH_REQ_DATA);

  // ==========================================================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wt(input int k, input logic v);
    int n;
    n = 0;
    while ((k == 0 ? READY_O : DATA_VALID_N_O) !== v && n < 400)
    begin
      @(posedge CLK);
      n++;
    end
    if (n >= 400)
      chk(0, 1);
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I <= w;
    WB_ADR_I <= a;
    WB_DAT_I <= d;
    @(posedge CLK);
    while (WB_ACK_O !== 1'b1)
    begin
      @(posedge CLK);
    end
    rd = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    @(posedge CLK);
  endtask

  task automatic hs(input logic [3:0] m, input logic [15:0] d, input logic r,
    input logic [15:0] e);
    wt(0, 1'b1);
    MODE_SELECT_BUS <= m;
    tb_d <= d;
    drv <= 1'b1;
    COMMAND_STROBE_N <= 1'b0;
    wt(0, 1'b0);
    MODE_SELECT_BUS <= 4'hF;
    drv <= 1'b0;
    if (r)
    begin
      OUTPUT_ENABLE_PIN_N <= 1'b0;
      wt(1, 1'b0);
      chk(PARALLEL_DATA_BUS_I, e);
      OUTPUT_ENABLE_PIN_N <= 1'b1;
      wt(1, 1'b1);
      chk(PARALLEL_DATA_BUS_OE, 0);
    end
    COMMAND_STROBE_N <= 1'b1;
    wt(0, 1'b1);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ==========================================================================
  // Stimulus
  initial
  begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end

  initial
  begin
    #200000;
    num_errors++;
    finish_test();
  end

  initial
  begin
    {RESET_N, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_DAT_I, drv, tb_d} = '0;
    {TEST_MODE_SELECT, PROG_ENABLE_SEL_A, PROG_ENABLE_SEL_B, PROG_ENABLE_SEL_C} = 4'hE;
    {COMMAND_STROBE_N, OUTPUT_ENABLE_PIN_N, MODE_SELECT_BUS, WB_SEL_I, lat} = 14'h3FF1;
    repeat (6) @(posedge CLK);
    chk({READY_OE, DATA_VALID_N_OE, PARALLEL_DATA_BUS_OE, GPIO_PULLUP_ALL, CLOCK_BYPASS,
      PORT_PULLUP_EN}, 6'h01);
    RESET_N <= 1'b1;
    repeat (4) @(posedge CLK);
    chk({GPIO_PULLUP_ALL, READY_OE, DATA_VALID_N_OE, READY_O}, 4'hF);
    chk(CLOCK_BYPASS, 1);
    wb(0, REG_VERSION, 0);
    chk(rd, 32'h1);
    wb(0, 8'h40, 0);
    chk(rd, 0);
    wb(0, REG_STATUS, 0);
    chk(rd[1:0], 2'h3);
    wb(1, REG_CTRL, 0);
    COMMAND_STROBE_N <= 1'b0;
    repeat (8) @(posedge CLK);
    chk(READY_O, 1);
    COMMAND_STROBE_N <= 1'b1;
    repeat (3) @(posedge CLK);
    wb(1, REG_CTRL, 1);
    $display("test registers done");
    foreach (CODES[i])
    begin
      hs(MODE_CMD, CODES[i], 0, 0);
      wb(0, REG_COMMAND, 0);
      chk(rd[15:0], CODES[i]);
    end
    hs(4'h6, 16'h5555, 0, 0);
    hs(4'hF, 16'h0022, 0, 0);
    wb(0, REG_COMMAND, 0);
    chk(rd[15:0], CMD_GET_VERSION);
    wb(0, REG_ADDRESS, 0);
    chk(rd, 0);
    chk(rq.size(), 0);
    $display("test commands done");
    hs(MODE_CMD, CMD_READ, 0, 0);
    hs(MODE_ADDR_A, 16'h0010, 0, 0);
    hs(MODE_ADDR_A + 4'h1, 16'h0002, 0, 0);
    hs(MODE_ADDR_D, 16'h7777, 0, 0);
    wb(0, REG_ADDRESS, 0);
    chk(rd, 32'h0002_0010);
    hs(MODE_DATA, 0, 1, 16'h0010 ^ 16'hA5A5);
    lat <= 4'h9;
    hs(MODE_DATA, 0, 1, 16'h0011 ^ 16'hA5A5);
    chk(rq[1].op, FOP_READ);
    chk(rq[1].addr, 32'h0002_0011);
    hs(MODE_CMD, CMD_GET_VERSION, 0, 0);
    hs(MODE_DATA, 0, 1, 16'h0012 ^ 16'hA5A5);
    chk(rq[2].op, FOP_EXEC);
    wb(0, REG_ADDRESS, 0);
    chk(rd, 32'h0002_0012);
    $display("test read done");
    rq.delete();
    hs(MODE_CMD, CMD_WRITE_PAGE, 0, 0);
    hs(MODE_ADDR_A, 16'h007F, 0, 0);
    hs(MODE_ADDR_A + 4'h1, 16'h0000, 0, 0);
    hs(MODE_DATA, 16'hBEEF, 0, 0);
    hs(MODE_DATA, 16'hCAFE, 0, 0);
    wb(0, REG_STATUS, 0);
    chk(rd[STAT_DIRTY_BIT], 1);
    hs(MODE_CMD, CMD_ERASE_ALL, 0, 0);
    hs(MODE_DATA, 16'h0003, 0, 0);
    chk(rq.size(), 5);
    chk({rq[0].op, rq[0].addr[7:0], rq[0].wdata}, {FOP_LOAD, 8'h7F, 16'hBEEF});
    chk({rq[1].op, rq[1].addr[7:0]}, {FOP_COMMIT, 8'h00});
    chk({rq[2].op, rq[2].addr[7:0], rq[2].wdata}, {FOP_LOAD, 8'h80, 16'hCAFE});
    chk({rq[3].op, rq[3].addr[7:0]}, {FOP_COMMIT, 8'h01});
    chk({rq[4].op, rq[4].cmd, rq[4].wdata[7:0]}, {FOP_EXEC, CMD_ERASE_ALL, 8'h03});
    hs(MODE_CMD, CMD_WRITE_MEMORY, 0, 0);
    hs(MODE_DATA, 16'h1234, 0, 0);
    chk({rq[5].op, rq[5].addr[7:0], rq[5].wdata}, {FOP_LOAD, 8'h81, 16'h1234});
    $display("test write done");
    finish_test();
  end
endmodule
